// *** src/spurious_interrupt_acknowledge_cycle_vector_logic.sv ***
// interrupt acknowledge vector return with spurious detection
// Functional notes
// R1 - detect spurious when acknowledged level has nothing
// R2 - other-level arrival clears spurious indication
// R3 - cleared indication then returns vector zero
// R4 - any other level, even lower, gives zero
// R5 - same-level arrival returns its own vector
// R6 - plain spurious acknowledge returns vector 24
// R7 - core raises mask before masking a source
// R8 - withdrawn or masked request makes acknowledge spurious
`include "spurious_interrupt_acknowledge_cycle_defines.svh"
module spurious_interrupt_acknowledge_cycle_vector_logic (
  input  wire logic                               clk,
  input  wire logic                               reset_n,
  input  wire logic [`NUM_SOURCES-1:0]            irq_pin,
  input  wire logic [`NUM_SOURCES-1:0]            source_mask_register,
  input  wire logic [`NUM_SOURCES*`LEVEL_W-1:0]   source_level,
  input  wire logic                               interrupt_acknowledge_cycle,
  input  wire logic [`LEVEL_W-1:0]                ack_level,
  output logic                                    vector_valid,
  output logic [`VECTOR_W-1:0]                    vector_number,
  output logic                                    spurious_flag,
  output logic [`LEVEL_W-1:0]                     highest_level
);
  import spurious_interrupt_acknowledge_cycle_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [`NUM_SOURCES-1:0] irq_meta_reg;
  logic [`NUM_SOURCES-1:0] irq_sync_reg;
  logic [`NUM_SOURCES-1:0] irq_prev_reg;

  // pins come from outside the clock, two stages before use
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_meta_reg <= '0;
      irq_sync_reg <= '0;
      irq_prev_reg <= '0;
    end else begin
      irq_meta_reg <= irq_pin;
      irq_sync_reg <= irq_meta_reg;
      irq_prev_reg <= irq_sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // masking a source simply drops it from the live set, so a masked
  // or withdrawn source can leave an acknowledge without a claimant
  wire logic [`NUM_SOURCES-1:0] req_live = irq_sync_reg & ~source_mask_register; // R8
  wire logic [`NUM_SOURCES-1:0] new_arrival = irq_sync_reg & ~irq_prev_reg & ~source_mask_register;

  // level of a source, used for arrival classification and priority
  function automatic logic [`LEVEL_W-1:0] level_of(
    input logic [`NUM_SOURCES*`LEVEL_W-1:0] lv,
    input int                                idx
  );
    level_of = lv[idx*`LEVEL_W +: `LEVEL_W];
  endfunction

  // ----------------------------------------------------------------
  // state and held values
  // ----------------------------------------------------------------
  ack_state_t                state_reg,     state_next;
  logic [1:0]                count_reg,     count_next;
  logic [`LEVEL_W-1:0]       lvl_reg,       lvl_next;
  logic                      spur_reg,      spur_next;
  logic                      other_reg,     other_next;
  logic                      vvalid_reg,    vvalid_next;
  logic [`VECTOR_W-1:0]      vnum_reg,      vnum_next;
  logic [`LEVEL_W-1:0]       hi_reg,        hi_next;
  logic                      ack_prev_reg;

  wire logic                       scan_hit;
  wire logic [`SOURCE_IDX_W-1:0]   scan_idx;

  // one scan serves both the start check and the final lookup
  level_pending_scan u_scan (
    .req_live   (req_live),
    .src_level  (source_level),
    .scan_level (state_reg == ACK_IDLE ? ack_level : lvl_reg),
    .level_hit  (scan_hit),
    .level_idx  (scan_idx)
  );

  wire logic ack_start = interrupt_acknowledge_cycle && !ack_prev_reg;

  // arrivals at other levels versus the acknowledged one
  logic arrive_other;
  logic [`LEVEL_W-1:0] hi_level;
  always_comb begin
    arrive_other = 1'b0;
    hi_level     = `RESET_LEVEL;
    for (int i = 0; i < `NUM_SOURCES; i++) begin
      if (new_arrival[i] && level_of(source_level, i) != lvl_reg) begin
        arrive_other = 1'b1;  // R4
      end
      if (req_live[i] && level_of(source_level, i) > hi_level) begin
        hi_level = level_of(source_level, i);
      end
    end
  end

  // ----------------------------------------------------------------
  // acknowledge sequencer
  // ----------------------------------------------------------------
  // the spurious indication is kept across the lookup; an arrival at
  // another level wipes it, which reproduces the silicon behaviour
  always_comb begin
    state_next  = state_reg;
    count_next  = count_reg;
    lvl_next    = lvl_reg;
    spur_next   = spur_reg;
    other_next  = other_reg;
    vvalid_next = 1'b0;
    vnum_next   = vnum_reg;
    hi_next     = hi_level;
    case (state_reg)
      ACK_IDLE: begin
        if (ack_start) begin
          state_next = ACK_LOOKUP;
          count_next = `LOOKUP_CYCLES;
          lvl_next   = ack_level;
          spur_next  = !scan_hit;  // R1
          other_next = 1'b0;
        end
      end
      ACK_LOOKUP: begin
        if (spur_reg && arrive_other) begin
          spur_next  = 1'b0;  // R2
          other_next = 1'b1;
        end
        if (count_reg == 2'h1) begin
          state_next = ACK_ANSWER;
        end
        count_next = count_reg - 2'h1;
      end
      ACK_ANSWER: begin
        vvalid_next = 1'b1;
        state_next  = ACK_IDLE;
        // a claimant withdrawn during the lookup is spurious as well, so
        // only a cleared indication may fall through to vector zero
        if (scan_hit) begin
          // same-level arrival claims the acknowledge
          vnum_next = `VECTOR_BASE + {3'h0, scan_idx};  // R5
        end else if (other_reg) begin
          vnum_next = `VECTOR_ZERO;  // R3
        end else begin
          vnum_next = `VECTOR_SPURIOUS;  // R6 R8
        end
      end
      default: begin
        state_next = ACK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg    <= ACK_IDLE;
      count_reg    <= 2'h0;
      lvl_reg      <= `RESET_LEVEL;
      spur_reg     <= 1'b0;
      other_reg    <= 1'b0;
      vvalid_reg   <= 1'b0;
      vnum_reg     <= `RESET_VECTOR;
      hi_reg       <= `RESET_LEVEL;
      ack_prev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      count_reg    <= count_next;
      lvl_reg      <= lvl_next;
      spur_reg     <= spur_next;
      other_reg    <= other_next;
      vvalid_reg   <= vvalid_next;
      vnum_reg     <= vnum_next;
      hi_reg       <= hi_next;
      ack_prev_reg <= interrupt_acknowledge_cycle;
    end
  end

  // outputs straight from flip-flops
  assign vector_valid  = vvalid_reg;
  assign vector_number = vnum_reg;
  assign spurious_flag = spur_reg;
  assign highest_level = hi_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_start_empty;
    state_reg == ACK_IDLE && ack_start && !scan_hit;
  endsequence

  // the answer flop is loaded at the third edge and seen at the fourth
  sequence s_answer;
    ##4 vector_valid;
  endsequence

  AST_SPUR_DETECT: assert property (@(posedge clk) disable iff (!reset_n) // R1
    s_start_empty |=> spurious_flag)
    else $error("empty level start did not raise spurious indication");

  AST_OTHER_CLEARS: assert property (@(posedge clk) disable iff (!reset_n) // R2
    (state_reg == ACK_LOOKUP && spur_reg && arrive_other) |=> !spurious_flag)
    else $error("other level arrival did not clear spurious indication");

  AST_ZERO_VECTOR: assert property (@(posedge clk) disable iff (!reset_n) // R3
    (state_reg == ACK_ANSWER && other_reg && !scan_hit)
      |=> vector_valid && vector_number == 8'h00)
    else $error("cleared spurious did not return vector zero");

  AST_ANY_LEVEL: assert property (@(posedge clk) disable iff (!reset_n) // R4
    (state_reg == ACK_LOOKUP && spur_reg && new_arrival != '0 && arrive_other)
      |=> other_reg)
    else $error("lower or higher level arrival not recorded");

  AST_SAME_LEVEL: assert property (@(posedge clk) disable iff (!reset_n) // R5
    (state_reg == ACK_ANSWER && scan_hit)
      |=> vector_valid && vector_number == $past(`VECTOR_BASE + {3'h0, scan_idx}))
    else $error("same level arrival did not get its own vector");

  AST_SPUR_VECTOR: assert property (@(posedge clk) disable iff (!reset_n) // R6
    (state_reg == ACK_ANSWER && !other_reg && !scan_hit)
      |=> vector_valid && vector_number == 8'h18)
    else $error("plain spurious acknowledge did not return vector 24");

  AST_ANSWER_TIME: assert property (@(posedge clk) disable iff (!reset_n) // answer timing of every acknowledge start
    (state_reg == ACK_IDLE && ack_start) |-> s_answer)
    else $error("answer not three cycles after acknowledge start");

  AST_MASKED_EMPTY: assert property (@(posedge clk) disable iff (!reset_n) // R8
    (state_reg == ACK_IDLE && ack_start && (req_live == '0)) |=> spurious_flag)
    else $error("fully masked request set not treated as spurious");
endmodule

// *** src/spurious_interrupt_acknowledge_cycle_defines.svh ***
// constants of the spurious acknowledge vector path
`ifndef SPURIOUS_INTERRUPT_ACKNOWLEDGE_CYCLE_DEFINES_SVH
`define SPURIOUS_INTERRUPT_ACKNOWLEDGE_CYCLE_DEFINES_SVH
`define NUM_SOURCES        32
`define LEVEL_W            3
`define VECTOR_W           8
`define SOURCE_IDX_W       5
`define VECTOR_ZERO        8'h00
`define VECTOR_SPURIOUS    8'h18
`define VECTOR_BASE        8'h40
`define LOOKUP_CYCLES      2'h2
`define RESET_VECTOR       8'h00
`define RESET_LEVEL        3'h0
`endif

// *** src/spurious_interrupt_acknowledge_cycle_pkg.sv ***
// types of the spurious acknowledge vector path
package spurious_interrupt_acknowledge_cycle_pkg;
  typedef enum logic [1:0] {
    ACK_IDLE,
    ACK_LOOKUP,
    ACK_ANSWER
  } ack_state_t;
  typedef enum logic [1:0] {
    OUT_NORMAL,
    OUT_SPURIOUS,
    OUT_ZERO
  } ack_outcome_t;
endpackage

// *** src/level_pending_scan.sv ***
// scan of masked requests at the asked level into one pending flag and lowest source index
`include "spurious_interrupt_acknowledge_cycle_defines.svh"
module level_pending_scan (
  input  wire logic [`NUM_SOURCES-1:0]                 req_live,
  input  wire logic [`NUM_SOURCES*`LEVEL_W-1:0]        src_level,
  input  wire logic [`LEVEL_W-1:0]                     scan_level,
  output logic                                         level_hit,
  output logic [`SOURCE_IDX_W-1:0]                     level_idx
);
  // one match bit per source at the asked level
  wire logic [`NUM_SOURCES-1:0] match;
  genvar g;
  generate
    for (g = 0; g < `NUM_SOURCES; g = g + 1) begin : g_match
      assign match[g] = req_live[g] &&
                        (src_level[g*`LEVEL_W +: `LEVEL_W] == scan_level);
    end
  endgenerate

  // lowest index wins inside one level
  always_comb begin
    level_hit = 1'b0;
    level_idx = '0;
    for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
      if (match[i]) begin
        level_hit = 1'b1;
        level_idx = i[`SOURCE_IDX_W-1:0];
      end
    end
  end
endmodule

// *** dv/interrupt_acknowledge_cycle_core_model.sv ***
// core-side model that runs interrupt acknowledge cycles
`include "spurious_interrupt_acknowledge_cycle_defines.svh"
module interrupt_acknowledge_cycle_core_model (
  input  wire logic                 clk,
  input  wire logic                 vector_valid,
  input  wire logic [`VECTOR_W-1:0] vector_number,
  output logic                      interrupt_acknowledge_cycle,
  output logic [`LEVEL_W-1:0]       ack_level
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    interrupt_acknowledge_cycle = 1'b0;
    ack_level = 3'h0;
  end
  // request held until the answer edge; hold > 0 keeps it up to show no restart
  task automatic acknowledge(input logic [2:0] lvl, input int hold,
                             output logic [7:0] vec, output int extra);
    int n;
    n = 0;
    extra = 0;
    vec = 8'hXX;
    @(posedge clk);
    #1;
    interrupt_acknowledge_cycle = 1'b1;
    ack_level = lvl;
    // look 1 ns after each edge so the answer flop has settled
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (vector_valid !== 1'b1 && n < 8);
    if (vector_valid === 1'b1) vec = vector_number;
    repeat (hold) begin
      @(posedge clk);
      #1;
      if (vector_valid === 1'b1) extra++;
    end
    interrupt_acknowledge_cycle = 1'b0;
    ack_level = ~lvl; // released level is garbage, never sampled
  endtask
endmodule

// *** dv/tb_top.sv ***
// self-checking bench of the spurious acknowledge vector path
`include "spurious_interrupt_acknowledge_cycle_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [31:0] irq;
    logic [31:0] msk;
    logic [2:0]  lvl;
    logic [7:0]  vec;
    logic        spur;
    logic [2:0]  hi;
  } row_t;
  // source i sits at level i mod 8, so lowest source at level l is l
  row_t rows [5] = '{
    '{32'h0000_0008, 32'h0000_0000, 3'h3, 8'h43, 1'b0, 3'h3},
    '{32'h0000_0808, 32'h0000_0008, 3'h3, 8'h4B, 1'b0, 3'h3},
    '{32'h8000_0000, 32'h0000_0000, 3'h7, 8'h5F, 1'b0, 3'h7},
    '{32'h0000_0008, 32'h0000_0000, 3'h5, 8'h18, 1'b1, 3'h3},
    '{32'h0000_0080, 32'h0000_0080, 3'h7, 8'h18, 1'b1, 3'h0}
  };
  logic        clk = 1'b0;
  logic        reset_n;
  logic [31:0] irq_pin;
  logic [31:0] source_mask_register;
  logic [95:0] source_level;
  logic        ack;
  logic [2:0]  ack_level;
  logic        vector_valid;
  logic [7:0]  vector_number;
  logic        spurious_flag;
  logic [2:0]  highest_level;
  logic [7:0]  vec;
  int          extra;
  int          miscompares = 0;
  int          tests_run = 0;
  always #50 clk = ~clk;
  spurious_interrupt_acknowledge_cycle_vector_logic spurious_interrupt_acknowledge_cycle_vector_logic_i (
    .clk(clk), .reset_n(reset_n), .irq_pin(irq_pin),
    .source_mask_register(source_mask_register), .source_level(source_level),
    .interrupt_acknowledge_cycle(ack), .ack_level(ack_level),
    .vector_valid(vector_valid), .vector_number(vector_number),
    .spurious_flag(spurious_flag), .highest_level(highest_level));
  interrupt_acknowledge_cycle_core_model interrupt_acknowledge_cycle_core_model_i (
    .clk(clk), .vector_valid(vector_valid), .vector_number(vector_number),
    .interrupt_acknowledge_cycle(ack), .ack_level(ack_level));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // pins need three synchroniser edges, five leaves margin
  task automatic settle(input logic [31:0] irq, input logic [31:0] msk);
    @(posedge clk);
    #1;
    irq_pin = irq;
    source_mask_register = msk;
    repeat (5) @(posedge clk);
  endtask
  // callers stand at time 0 or 1 ns after an edge, so reset covers exactly 3 edges
  task automatic pulse_reset();
    reset_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({vector_valid, spurious_flag, highest_level}, 8'h00, "reset flags");
    chk(vector_number, 8'h00, "reset vector");
    reset_n = 1'b1;
    $display("reset test done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    reset_n = 1'b0;
    irq_pin = '0;
    source_mask_register = '0;
    for (int i = 0; i < 32; i++) source_level[3*i+:3] = 3'(i);
    pulse_reset();
    // masks change only between acknowledges, as the core must do
    foreach (rows[r]) begin
      settle(rows[r].irq, rows[r].msk);
      chk(highest_level, rows[r].hi, "highest level");
      interrupt_acknowledge_cycle_core_model_i.acknowledge(rows[r].lvl, 0, vec, extra);
      chk(vec, rows[r].vec, "row vector");
      chk(spurious_flag, rows[r].spur, "row spurious");
      $display("row %0d done", r);
    end
    // spurious at level 4 while any level 1 to 7 arrives, lower ones too
    for (int l = 1; l < 8; l++) begin
      settle(32'h0, 32'h0);
      @(posedge clk);
      #1;
      irq_pin = 32'h1 << l;
      interrupt_acknowledge_cycle_core_model_i.acknowledge(3'h4, 0, vec, extra);
      if (l == 4) begin
        chk(vec, 8'h44, "same level arrival");
      end else begin
        chk(vec, 8'h00, "other level arrival");
        chk(spurious_flag, 1'b0, "flag cleared");
      end
    end
    $display("overlap test done");
    // a request held high is answered once only
    settle(32'h8, 32'h0);
    interrupt_acknowledge_cycle_core_model_i.acknowledge(3'h3, 6, vec, extra);
    chk(vec, 8'h43, "held vector");
    chk(8'(extra), 8'h00, "no second answer");
    settle(32'h0, 32'h0);
    interrupt_acknowledge_cycle_core_model_i.acknowledge(3'h6, 0, vec, extra);
    chk(vec, 8'h18, "plain spurious");
    // claimant pin dropped as the acknowledge is raised, one edge before the start edge, no other arrival
    settle(32'h8, 32'h0);
    fork
      interrupt_acknowledge_cycle_core_model_i.acknowledge(3'h3, 0, vec, extra);
      begin
        @(posedge clk);
        #1;
        irq_pin = 32'h0;
      end
    join
    chk(vec, 8'h18, "withdrawn request");
    $display("held, plain and withdrawn tests done");
    pulse_reset();
    give_verdict();
  end
  // cut a hang short well beyond the expected run length
  initial begin
    #200000;
    miscompares++;
    $display("unexpected at %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
